//--- core/adc_pkg.sv
package adc_pkg;
    // word offsets of the byte registers on the 32-bit bus
    localparam int         ADDR_W           = 8;
    localparam logic [7:0] OFS_RESULT_LOW   = 8'h00;
    localparam logic [7:0] OFS_RESULT_HIGH  = 8'h04;
    localparam logic [7:0] OFS_CONTROL_ZERO = 8'h08;
    localparam logic [7:0] OFS_CONTROL_ONE  = 8'h0C;
    localparam logic [7:0] OFS_PIN_ENABLE   = 8'h10;

    // control zero fields
    localparam int CR0_START_BIT   = 7;
    localparam int CR0_BUSY_BIT    = 6;
    localparam int CR0_PD_BIT      = 5;
    localparam int CR0_JUSTIFY_BIT = 4;
    localparam int CR0_CHAN_LSB    = 0;

    // control one fields
    localparam int CR1_BGSEL_BIT = 7;
    localparam int CR1_BGEN_BIT  = 6;
    localparam int CR1_REF_BIT   = 4;
    localparam int CR1_DIV_LSB   = 0;

    // reset values
    localparam logic [7:0] CR0_RESET     = 8'h60;
    localparam logic [7:0] CR1_RESET     = 8'h00;
    localparam logic [7:0] PIN_EN_RESET  = 8'hFF;

    // widths and source numbering
    localparam int RESULT_W    = 12;
    localparam int CHAN_W      = 4;
    localparam int DIV_W       = 3;
    localparam int DIV_CNT_W   = 6;
    localparam int NUM_PINS    = 8;
    localparam int NUM_SOURCES = 10;
    localparam int SRC_AMP     = 8;
    localparam int SRC_BANDGAP = 9;

    localparam logic [DIV_W-1:0] DIV_CODE_UNDEF = 3'h7;
endpackage

//--- core/adc_clock_divider.sv
`timescale 1ns/100ps
module adc_clock_divider
    import adc_pkg::*;
#(
    parameter int CODE_W = DIV_W,
    parameter int CNT_W  = DIV_CNT_W
) (
    // clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // control
    input  wire logic              run_i,
    input  wire logic [CODE_W-1:0] code_i,
    // conversion clock enable
    output logic                   tick_o
);
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [3:0]       shift_amt;
    logic [CNT_W-1:0] mask;

    // code n gives one tick every 2**n system clocks
    assign shift_amt = 4'(CNT_W) - 4'(code_i);
    assign mask      = {CNT_W{1'b1}} >> shift_amt;
    // the undefined code simply stops the conversion clock
    assign tick_o    = run_i && (code_i != DIV_CODE_UNDEF) && ((cnt_reg & mask) == mask);
    assign cnt_next  = run_i ? cnt_reg + 1'b1 : '0;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_reg <= '0;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    property p_div_by_four;
        @(posedge clk_i) disable iff (rst_i)
        (tick_o && code_i == 3'h2 && run_i) ##1 (run_i && code_i == 3'h2) [*4]
            |-> !$past(tick_o) && tick_o;
    endproperty
    a_div_by_four: assert property (p_div_by_four) else $error("divide by four spacing wrong");
endmodule

//--- core/adc_channel_router.sv
`timescale 1ns/100ps
module adc_channel_router
    import adc_pkg::*;
(
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // selection
    input  wire logic                   bandgap_sel_i,
    input  wire logic [CHAN_W-1:0]      code_i,
    // one-hot source select towards the analog mux
    output logic [NUM_SOURCES-1:0]      sel_o
);
    logic [NUM_SOURCES-1:0] sel_next;

    assign sel_next = bandgap_sel_i ? NUM_SOURCES'(1) << SRC_BANDGAP
                    : code_i[CHAN_W-1] ? NUM_SOURCES'(1) << SRC_AMP
                    : NUM_SOURCES'(1) << code_i[CHAN_W-2:0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_o <= NUM_SOURCES'(1);
        end else begin
            sel_o <= sel_next;
        end
    end

    property p_pin_route;
        @(posedge clk_i) disable iff (rst_i)
        (!bandgap_sel_i && !code_i[3]) |=> sel_o == (10'h001 << $past(code_i[2:0]));
    endproperty
    a_pin_route: assert property (p_pin_route) else $error("pin channel not routed");

    property p_amp_route;
        @(posedge clk_i) disable iff (rst_i)
        (!bandgap_sel_i && code_i[3]) |=> sel_o == 10'h100;
    endproperty
    a_amp_route: assert property (p_amp_route) else $error("amplifier not routed");

    property p_bandgap_route;
        @(posedge clk_i) disable iff (rst_i)
        bandgap_sel_i |=> sel_o == 10'h200;
    endproperty
    a_bandgap_route: assert property (p_bandgap_route) else $error("bandgap not exclusive");
endmodule

//--- core/adc_control_registers.sv
`timescale 1ns/100ps
// Notes on behaviour
// - result is twelve bits over two bytes
// - justify clear: left aligned, low nibble zero
// - justify set: right aligned, high nibble zero
// - unused result bits read zero
// - start high then low launches conversion unless power down is set
// - start high resets converter, busy forced one
// - busy reads conversion state, writes ignored
// - end clears busy and raises interrupt request
// - power down bit switches converter off, resets one
// - channel codes 0 to 7 pick pins
// - channel top bit picks amplifier output
// - bandgap select overrides all other inputs
// - bandgap off when unused and supervisors off
// - reference select: supply or external pin
// - clock field divides by 1 to 64
// - pin enable makes pin analog, removes digital
// - analog pin loses its pull-high
// - control one bits 5 and 3 read zero
module adc_control_registers
    import adc_pkg::*;
(
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   rst_i,
    // wishbone slave
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [ADDR_W-1:0]      wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic [31:0]                 wb_dat_o,
    output logic                        wb_ack_o,
    // analog converter core
    output logic                        conv_reset_o,
    output logic                        conv_start_o,
    output logic                        conv_clk_en_o,
    output logic                        conv_power_down_o,
    output logic                        conv_ref_external_o,
    output logic [NUM_SOURCES-1:0]      conv_channel_sel_o,
    input  wire logic [RESULT_W-1:0]    conv_data_i,
    input  wire logic                   conv_done_i,
    // bandgap and supervisors
    input  wire logic                   lvr_enable_i,
    input  wire logic                   lvd_enable_i,
    output logic                        bandgap_on_o,
    // request to the interrupt controller
    output logic                        adc_irq_o,
    // port pins
    input  wire logic [NUM_PINS-1:0]    pad_in_i,
    output logic [NUM_PINS-1:0]         port_in_o,
    input  wire logic [NUM_PINS-1:0]    port_oe_i,
    output logic [NUM_PINS-1:0]         pad_oe_o,
    input  wire logic [NUM_PINS-1:0]    pullhigh_req_i,
    output logic [NUM_PINS-1:0]         pullhigh_en_o,
    output logic [NUM_PINS-1:0]         analog_pin_enable_o
);
    function automatic logic reg_hit(input logic [ADDR_W-1:0] adr, input logic [7:0] ofs);
        reg_hit = (adr[ADDR_W-1:2] == ofs[ADDR_W-1:2]);
    endfunction

    // bus side
    logic                 ack_reg;
    logic [31:0]          rdata_reg;
    logic                 req;
    logic                 wr_en;
    logic                 byte0_wr;
    logic                 hit_low;
    logic                 hit_high;
    logic                 hit_cr0;
    logic                 hit_cr1;
    logic                 hit_pin;
    logic [7:0]           wbyte;
    logic [7:0]           rd_byte;

    // control state
    logic                 start_reg;
    logic                 start_next;
    logic                 busy_reg;
    logic                 busy_next;
    logic                 pd_reg;
    logic                 justify_reg;
    logic [CHAN_W-1:0]    chan_reg;
    logic                 bg_sel_reg;
    logic                 bg_en_reg;
    logic                 ref_reg;
    logic [DIV_W-1:0]     div_reg;
    logic [NUM_PINS-1:0]  pin_en_reg;
    logic [7:0]           cr0_view;
    logic [7:0]           cr1_view;

    // conversion sequencing
    logic                 launch;
    logic                 capture;
    logic                 conv_start_reg;
    logic                 active_reg;
    logic                 pending_reg;
    logic                 irq_reg;
    logic [RESULT_W-1:0]  result_reg;
    logic [7:0]           res_low_byte;
    logic [7:0]           res_high_byte;

    // pad synchroniser
    logic [NUM_PINS-1:0]  pad_meta_reg;
    logic [NUM_PINS-1:0]  pad_sync_reg;

    // --------------------------------------------------------------- bus decode
    assign req      = wb_cyc_i && wb_stb_i;
    // a write lands on the edge at which the master sees ack
    assign wr_en    = req && wb_we_i && ack_reg;
    assign byte0_wr = wr_en && wb_sel_i[0];
    assign wbyte    = wb_dat_i[7:0];
    assign hit_low  = reg_hit(wb_adr_i, OFS_RESULT_LOW);
    assign hit_high = reg_hit(wb_adr_i, OFS_RESULT_HIGH);
    assign hit_cr0  = reg_hit(wb_adr_i, OFS_CONTROL_ZERO);
    assign hit_cr1  = reg_hit(wb_adr_i, OFS_CONTROL_ONE);
    assign hit_pin  = reg_hit(wb_adr_i, OFS_PIN_ENABLE);

    // --------------------------------------------------------------- result views
    assign res_low_byte  = justify_reg ? result_reg[7:0]
                                       : {result_reg[3:0], 4'h0};
    assign res_high_byte = justify_reg ? {4'h0, result_reg[11:8]}
                                       : result_reg[11:4];

    assign cr0_view = {start_reg, busy_reg, pd_reg, justify_reg, chan_reg};
    assign cr1_view = {bg_sel_reg, bg_en_reg, 1'b0, ref_reg, 1'b0, div_reg};

    // unmapped addresses answer with zero
    assign rd_byte = hit_low  ? res_low_byte  :
                     hit_high ? res_high_byte :
                     hit_cr0  ? cr0_view      :
                     hit_cr1  ? cr1_view      :
                     hit_pin  ? pin_en_reg    : 8'h00;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ack_reg   <= req && !ack_reg;
            rdata_reg <= {24'h00_0000, rd_byte};
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    // --------------------------------------------------------------- control registers
    // start only falls through a software write; the fall is the launch unless pd_reg is set
    assign start_next = (byte0_wr && hit_cr0) ? wbyte[CR0_START_BIT] : start_reg;
    assign launch     = start_reg && !start_next && !pd_reg;
    assign capture    = conv_done_i && active_reg && !start_reg;

    // busy has no write path; it follows start and the end of conversion
    always_comb begin
        busy_next = busy_reg;
        if (start_next) begin
            busy_next = 1'b1;
        end else if (pending_reg) begin
            busy_next = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            start_reg   <= CR0_RESET[CR0_START_BIT];
            busy_reg    <= CR0_RESET[CR0_BUSY_BIT];
            pd_reg      <= CR0_RESET[CR0_PD_BIT];
            justify_reg <= CR0_RESET[CR0_JUSTIFY_BIT];
            chan_reg    <= CR0_RESET[CR0_CHAN_LSB +: CHAN_W];
        end else begin
            start_reg <= start_next;
            busy_reg  <= busy_next;
            if (byte0_wr && hit_cr0) begin
                pd_reg      <= wbyte[CR0_PD_BIT];
                justify_reg <= wbyte[CR0_JUSTIFY_BIT];
                chan_reg    <= wbyte[CR0_CHAN_LSB +: CHAN_W];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bg_sel_reg <= CR1_RESET[CR1_BGSEL_BIT];
            bg_en_reg  <= CR1_RESET[CR1_BGEN_BIT];
            ref_reg    <= CR1_RESET[CR1_REF_BIT];
            div_reg    <= CR1_RESET[CR1_DIV_LSB +: DIV_W];
            pin_en_reg <= PIN_EN_RESET;
        end else begin
            if (byte0_wr && hit_cr1) begin
                bg_sel_reg <= wbyte[CR1_BGSEL_BIT];
                bg_en_reg  <= wbyte[CR1_BGEN_BIT];
                ref_reg    <= wbyte[CR1_REF_BIT];
                div_reg    <= wbyte[CR1_DIV_LSB +: DIV_W];
            end
            if (byte0_wr && hit_pin) begin
                pin_en_reg <= wbyte;
            end
        end
    end

    // --------------------------------------------------------------- conversion
    // result lands one edge before busy drops, so a poller never sees a stale pair
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            conv_start_reg <= 1'b0;
            active_reg     <= 1'b0;
            pending_reg    <= 1'b0;
            irq_reg        <= 1'b0;
            result_reg     <= '0;
        end else begin
            conv_start_reg <= launch;
            irq_reg        <= pending_reg && !start_next;
            if (start_next || pd_reg) begin
                active_reg <= 1'b0;
            end else if (launch) begin
                active_reg <= 1'b1;
            end else if (capture) begin
                active_reg <= 1'b0;
            end
            pending_reg <= capture && !start_next;
            if (capture) begin
                result_reg <= conv_data_i;
            end
        end
    end

    assign conv_start_o        = conv_start_reg;
    assign conv_reset_o        = start_reg;
    assign conv_power_down_o   = pd_reg;
    assign conv_ref_external_o = ref_reg;
    assign adc_irq_o           = irq_reg;
    // the supervisors share the reference, so it stays up for them
    assign bandgap_on_o = (bg_en_reg && bg_sel_reg) || lvr_enable_i || lvd_enable_i;

    adc_clock_divider i_adc_clock_divider (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .run_i  (!pd_reg && !start_reg),
        .code_i (div_reg),
        .tick_o (conv_clk_en_o)
    );

    adc_channel_router i_adc_channel_router (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .bandgap_sel_i (bg_sel_reg),
        .code_i        (chan_reg),
        .sel_o         (conv_channel_sel_o)
    );

    // --------------------------------------------------------------- port pins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pad_meta_reg <= '0;
            pad_sync_reg <= '0;
        end else begin
            pad_meta_reg <= pad_in_i;
            pad_sync_reg <= pad_meta_reg;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NUM_PINS; gi = gi + 1) begin : g_pin
            assign port_in_o[gi]     = pad_sync_reg[gi] && !pin_en_reg[gi];
            assign pad_oe_o[gi]      = port_oe_i[gi] && !pin_en_reg[gi];
            assign pullhigh_en_o[gi] = pullhigh_req_i[gi] && !pin_en_reg[gi];
        end
    endgenerate

    assign analog_pin_enable_o = pin_en_reg;

    // --------------------------------------------------------------- checks
    sequence s_capture;
        conv_done_i && active_reg && !start_reg && !(byte0_wr && hit_cr0 && wbyte[7]);
    endsequence

    sequence s_finish(logic [RESULT_W-1:0] val);
        (result_reg == val && busy_reg) ##1 (!busy_reg && adc_irq_o);
    endsequence

    property p_end_of_conversion;
        logic [RESULT_W-1:0] v;
        @(posedge clk_i) disable iff (rst_i)
        (s_capture, v = conv_data_i) |=> s_finish(v);
    endproperty
    a_end_of_conversion: assert property (p_end_of_conversion) else $error("end sequence wrong");

    property p_irq_pulse;
        @(posedge clk_i) disable iff (rst_i)
        adc_irq_o |-> !busy_reg && $fell(busy_reg) ##1 !adc_irq_o;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt not tied to busy fall");

    property p_left_align;
        @(posedge clk_i) disable iff (rst_i)
        (req && !ack_reg && !justify_reg && hit_low) |=> wb_ack_o && wb_dat_o == {24'h0, $past(result_reg[3:0]), 4'h0};
    endproperty
    a_left_align: assert property (p_left_align) else $error("left aligned low byte wrong");

    property p_right_align;
        @(posedge clk_i) disable iff (rst_i)
        (req && !ack_reg && justify_reg && hit_high) |=> wb_dat_o == {28'h0, $past(result_reg[11:8])};
    endproperty
    a_right_align: assert property (p_right_align) else $error("right aligned high byte wrong");

    property p_start_holds_reset;
        @(posedge clk_i) disable iff (rst_i)
        start_reg |-> busy_reg && conv_reset_o && !conv_clk_en_o;
    endproperty
    a_start_holds_reset: assert property (p_start_holds_reset) else $error("start not resetting");

    property p_launch_on_fall;
        @(posedge clk_i) disable iff (rst_i)
        conv_start_o |-> $past(start_reg) && !start_reg && busy_reg;
    endproperty
    a_launch_on_fall: assert property (p_launch_on_fall) else $error("launch without start fall");

    property p_busy_not_writable;
        @(posedge clk_i) disable iff (rst_i)
        (busy_reg && !pending_reg && byte0_wr && hit_cr0 && !wbyte[6]) |=> busy_reg;
    endproperty
    a_busy_not_writable: assert property (p_busy_not_writable) else $error("busy cleared by write");

    property p_reserved_zero;
        @(posedge clk_i) disable iff (rst_i)
        (req && !ack_reg && hit_cr1) |=> wb_dat_o[5] == 1'b0 && wb_dat_o[3] == 1'b0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits not zero");

    property p_pullhigh_removed;
        @(posedge clk_i) disable iff (rst_i)
        (pullhigh_en_o & analog_pin_enable_o) == 8'h00 && (pad_oe_o & analog_pin_enable_o) == 8'h00;
    endproperty
    a_pullhigh_removed: assert property (p_pullhigh_removed) else $error("analog pin still digital");

    property p_bandgap_off;
        @(posedge clk_i) disable iff (rst_i)
        (!lvr_enable_i && !lvd_enable_i && !bg_sel_reg) |-> !bandgap_on_o;
    endproperty
    a_bandgap_off: assert property (p_bandgap_off) else $error("bandgap left on");
endmodule

//--- verif/adc_control_registers_test.sv
`timescale 1ns/100ps
module adc_control_registers_test
    import adc_pkg::*;
;
    logic                   clk_i = 1'b0;
    logic                   rst_i = 1'b1;
    logic                   wb_cyc_i = 1'b0;
    logic                   wb_stb_i = 1'b0;
    logic                   wb_we_i = 1'b0;
    logic [ADDR_W-1:0]      wb_adr_i = '0;
    logic [3:0]             wb_sel_i = 4'hF;
    logic [31:0]            wb_dat_i = '0;
    logic [31:0]            wb_dat_o;
    logic                   wb_ack_o;
    logic                   conv_reset_o, conv_start_o, conv_clk_en_o;
    logic                   conv_power_down_o, conv_ref_external_o, bandgap_on_o, adc_irq_o;
    logic [NUM_SOURCES-1:0] conv_channel_sel_o;
    logic [RESULT_W-1:0]    conv_data_i = '0;
    logic                   conv_done_i = 1'b0;
    logic                   lvr_enable_i = 1'b0;
    logic                   lvd_enable_i = 1'b0;
    logic [NUM_PINS-1:0]    pad_in_i = 8'hFF;
    logic [NUM_PINS-1:0]    port_oe_i = 8'hFF;
    logic [NUM_PINS-1:0]    pullhigh_req_i = 8'hFF;
    logic [NUM_PINS-1:0]    port_in_o, pad_oe_o, pullhigh_en_o, analog_pin_enable_o;
    int                     mismatches = 0;
    int                     comparisons = 0;
    int                     starts = 0;
    int                     irqs = 0;
    int                     ticks = 0;
    int                     snap;
    // rows: control one, channel code, expected one-hot source
    logic [21:0]            rows [12] = '{
        {8'h00, 4'h0, 10'h001}, {8'h00, 4'h1, 10'h002}, {8'h00, 4'h2, 10'h004},
        {8'h00, 4'h3, 10'h008}, {8'h00, 4'h4, 10'h010}, {8'h00, 4'h5, 10'h020},
        {8'h00, 4'h6, 10'h040}, {8'h00, 4'h7, 10'h080}, {8'h00, 4'h8, 10'h100},
        {8'h00, 4'hF, 10'h100}, {8'hC0, 4'h3, 10'h200}, {8'hC0, 4'h8, 10'h200}};

    adc_control_registers i_adc_control_registers (.*);

    initial begin
        forever #12.5 clk_i = ~clk_i;
    end

    // pulse counters, read only away from the rising edge
    always @(posedge clk_i) begin
        if (conv_start_o === 1'b1) starts <= starts + 1;
        if (adc_irq_o === 1'b1) irqs <= irqs + 1;
        if (conv_clk_en_o === 1'b1) ticks <= ticks + 1;
    end

    task automatic print_verdict();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        comparisons++;
        if (seen !== expv) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, expv);
        end
    endtask

    // request held until ack is seen high at a rising edge; read data taken at that edge
    task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] dat,
                      output logic [31:0] rd);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= {24'h0, dat};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        // a missing ack is counted and the run goes on to the report
        if (wb_ack_o !== 1'b1) begin
            mismatches++;
        end
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        @(negedge clk_i);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] dat);
        logic [31:0] d;
        wb(1'b1, adr, dat, d);
    endtask

    task automatic rdchk(input logic [7:0] adr, input logic [7:0] expv);
        logic [31:0] d;
        wb(1'b0, adr, 8'h00, d);
        check(d, {24'h0, expv});
    endtask

    task automatic pulse_done(input logic [11:0] d);
        @(posedge clk_i);
        conv_data_i <= d;
        conv_done_i <= 1'b1;
        @(posedge clk_i);
        conv_done_i <= 1'b0;
        repeat (4) @(negedge clk_i);
    endtask

    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        check(conv_power_down_o, 1'b1);
        check(conv_channel_sel_o, 10'h001);
        rdchk(OFS_CONTROL_ZERO, 8'h60);
        rdchk(OFS_CONTROL_ONE, 8'h00);
        rdchk(OFS_PIN_ENABLE, 8'hFF);
        foreach (rows[i]) begin
            wr(OFS_CONTROL_ONE, rows[i][21:14]);
            wr(OFS_CONTROL_ZERO, {4'h0, rows[i][13:10]});
            repeat (2) @(negedge clk_i);
            check(conv_channel_sel_o, rows[i][9:0]);
        end
        wr(OFS_CONTROL_ONE, 8'h40);
        wr(OFS_CONTROL_ONE, 8'hC0);
        repeat (8) @(negedge clk_i);
        check(conv_channel_sel_o, 10'h200);
        check(bandgap_on_o, 1'b1);
        wr(OFS_CONTROL_ZERO, 8'h80);
        @(negedge clk_i);
        check(conv_reset_o, 1'b1);
        rdchk(OFS_CONTROL_ZERO, 8'hC0);
        snap = irqs;
        pulse_done(12'h123);
        check(irqs, snap);
        snap = starts;
        wr(OFS_CONTROL_ZERO, 8'h00);
        repeat (3) @(negedge clk_i);
        check(starts, snap + 1);
        check(conv_reset_o, 1'b0);
        snap = irqs;
        pulse_done(12'hABC);
        check(irqs, snap + 1);
        rdchk(OFS_CONTROL_ZERO, 8'h00);
        rdchk(OFS_RESULT_HIGH, 8'hAB);
        rdchk(OFS_RESULT_LOW, 8'hC0);
        wr(OFS_CONTROL_ZERO, 8'h10);
        rdchk(OFS_RESULT_HIGH, 8'h0A);
        rdchk(OFS_RESULT_LOW, 8'hBC);
        wr(OFS_CONTROL_ZERO, 8'h40);
        rdchk(OFS_CONTROL_ZERO, 8'h00);
        snap = starts;
        wr(OFS_CONTROL_ZERO, 8'hA0);
        wr(OFS_CONTROL_ZERO, 8'h20);
        repeat (3) @(negedge clk_i);
        check(starts, snap);
        rdchk(OFS_CONTROL_ZERO, 8'h60);
        wr(OFS_CONTROL_ZERO, 8'h00);
        check(conv_power_down_o, 1'b0);
        // settle each divider code before counting a 64-cycle window
        for (int c = 0; c < 8; c++) begin
            wr(OFS_CONTROL_ONE, 8'(c));
            repeat (130) @(negedge clk_i);
            snap = ticks;
            repeat (64) @(negedge clk_i);
            check(ticks - snap, (c == 7) ? 0 : (64 >> c));
        end
        wr(OFS_CONTROL_ONE, 8'hFF);
        rdchk(OFS_CONTROL_ONE, 8'hD7);
        check(conv_ref_external_o, 1'b1);
        check(bandgap_on_o, 1'b1);
        wr(OFS_CONTROL_ONE, 8'h40);
        check(conv_ref_external_o, 1'b0);
        check(bandgap_on_o, 1'b0);
        @(posedge clk_i);
        lvd_enable_i <= 1'b1;
        @(negedge clk_i);
        check(bandgap_on_o, 1'b1);
        @(posedge clk_i);
        lvd_enable_i <= 1'b0;
        lvr_enable_i <= 1'b1;
        @(negedge clk_i);
        check(bandgap_on_o, 1'b1);
        wr(OFS_PIN_ENABLE, 8'h0F);
        repeat (4) @(negedge clk_i);
        rdchk(OFS_PIN_ENABLE, 8'h0F);
        check(analog_pin_enable_o, 8'h0F);
        check(pad_oe_o, 8'hF0);
        check(port_in_o, 8'hF0);
        check(pullhigh_en_o, 8'hF0);
        rdchk(8'h14, 8'h00);
        // a write with the low byte lane off must leave the register alone
        @(posedge clk_i);
        wb_sel_i <= 4'hE;
        wr(OFS_PIN_ENABLE, 8'h00);
        rdchk(OFS_PIN_ENABLE, 8'h0F);
        @(posedge clk_i);
        wb_sel_i <= 4'hF;
        wr(OFS_CONTROL_ZERO, 8'h20);
        check(conv_power_down_o, 1'b1);
        // reset in mid-run returns every register to its power-on value
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(negedge clk_i);
        check(analog_pin_enable_o, 8'hFF);
        rdchk(OFS_CONTROL_ZERO, 8'h60);
        rdchk(OFS_CONTROL_ONE, 8'h00);
        print_verdict();
    end
endmodule
